// [pwm_pkg.sv]
// Register map, field positions and reset values of the peak and warning monitor
`default_nettype none

package pwm_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_VIN = 8'h00;
  localparam logic [7:0] OFF_AUX = 8'h04;
  localparam logic [7:0] OFF_CUR = 8'h08;
  localparam logic [7:0] OFF_PWR = 8'h0c;
  localparam logic [7:0] OFF_PWR_WIDE = 8'h10;
  localparam logic [7:0] OFF_VIN_HIGH = 8'h14;
  localparam logic [7:0] OFF_AUX_HIGH = 8'h18;
  localparam logic [7:0] OFF_CUR_HIGH = 8'h1c;
  localparam logic [7:0] OFF_CUR_LOW = 8'h20;
  localparam logic [7:0] OFF_PWR_HIGH = 8'h24;
  localparam logic [7:0] OFF_PWR_LOW = 8'h28;
  localparam logic [7:0] OFF_VIN_OVER = 8'h2c;
  localparam logic [7:0] OFF_VIN_UNDER = 8'h30;
  localparam logic [7:0] OFF_AUX_OVER = 8'h34;
  localparam logic [7:0] OFF_AUX_UNDER = 8'h38;
  localparam logic [7:0] OFF_CUR_OVER = 8'h3c;
  localparam logic [7:0] OFF_PWR_OVER = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  localparam logic [7:0] OFF_EFWD_ACC = 8'h48;
  localparam logic [7:0] OFF_EFWD_ROLL = 8'h4c;
  localparam logic [7:0] OFF_EREV_ACC = 8'h50;
  localparam logic [7:0] OFF_EREV_ROLL = 8'h54;
  localparam logic [7:0] OFF_SAMPLES = 8'h58;
  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int unsigned ST_VIN_OV = 0;
  localparam int unsigned ST_VIN_UV = 1;
  localparam int unsigned ST_AUX_OV = 2;
  localparam int unsigned ST_AUX_UV = 3;
  localparam int unsigned ST_CUR_OC = 4;
  localparam int unsigned ST_PWR_OP = 5;
  localparam int unsigned ST_W = 6;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned CODE_W = 12;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned WIDE_W = 24;
  localparam int unsigned ROLL_W = 16;
  localparam logic [15:0] LIM_UNDER_RST = 16'h0000;
  localparam logic [15:0] LIM_VOLT_OVER_RST = 16'h0fff;
  localparam logic [15:0] LIM_SIGNED_OVER_RST = 16'h7fff;
  localparam logic [15:0] RECORD_CLEAR = 16'h0000;
endpackage

`default_nettype wire

// [pwm_monitor.sv]
// Peak record, limit warning and energy metering logic behind an APB slave
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwm_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fe_done_toggle,
  input wire logic [pwm_pkg::CODE_W-1:0] fe_vin_code,
  input wire logic [pwm_pkg::CODE_W-1:0] fe_aux_code,
  input wire logic [pwm_pkg::CODE_W-1:0] fe_cur_code,
  output logic [pwm_pkg::ST_W-1:0] warn_flags
);
  localparam int unsigned SYNC_W = 3 * pwm_pkg::CODE_W + 1;

  function automatic logic [15:0] smax(input logic [15:0] a,
                                        input logic [15:0] b);
    return ($signed(a) > $signed(b)) ? a : b;
  endfunction

  function automatic logic [15:0] smin(input logic [15:0] a,
                                        input logic [15:0] b);
    return ($signed(a) < $signed(b)) ? a : b;
  endfunction

  // ****************************************************************
  // Front end crossing
  // ****************************************************************
  // Front end sets its codes a full link period before each toggle, so
  // the words are settled by the time the delayed toggle shows an edge.
  logic [SYNC_W-1:0] fe_s1_r;
  logic [SYNC_W-1:0] fe_s2_r;
  logic tog_s3_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_s1_r <= '0;
      fe_s2_r <= '0;
      tog_s3_r <= 1'b0;
    end else begin
      fe_s1_r <= {fe_done_toggle, fe_vin_code, fe_aux_code, fe_cur_code};
      fe_s2_r <= fe_s1_r;
      tog_s3_r <= fe_s2_r[SYNC_W-1];
    end
  end

  wire new_res = fe_s2_r[SYNC_W-1] ^ tog_s3_r;
  wire [11:0] vin_code = fe_s2_r[35:24];
  wire [11:0] aux_code = fe_s2_r[23:12];
  wire [11:0] cur_code = fe_s2_r[11:0];

  // ****************************************************************
  // Result words
  // ****************************************************************
  wire [15:0] vin_w = {4'h0, vin_code};
  wire [15:0] aux_w = {4'h0, aux_code};
  wire [15:0] cur_w = {{4{cur_code[11]}}, cur_code};
  wire signed [24:0] prod_w = $signed({1'b0, vin_code}) * $signed(cur_code);
  wire [23:0] pwr_wide_w = prod_w[23:0];
  wire [15:0] pwr_w = pwr_wide_w[23:8];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic pready_r;
  wire wr_en = psel & penable & pready_r & pwrite;
  wire wr_zero = wr_en & (pwdata == 32'h0000_0000);
  wire clr_vin_h = wr_zero & (paddr == pwm_pkg::OFF_VIN_HIGH);
  wire clr_aux_h = wr_zero & (paddr == pwm_pkg::OFF_AUX_HIGH);
  wire clr_cur_h = wr_zero & (paddr == pwm_pkg::OFF_CUR_HIGH);
  wire clr_cur_l = wr_zero & (paddr == pwm_pkg::OFF_CUR_LOW);
  wire clr_pwr_h = wr_zero & (paddr == pwm_pkg::OFF_PWR_HIGH);
  wire clr_pwr_l = wr_zero & (paddr == pwm_pkg::OFF_PWR_LOW);
  wire sts_clr = wr_en & (paddr == pwm_pkg::OFF_STATUS);
  wire wr_vin_ov = wr_en & (paddr == pwm_pkg::OFF_VIN_OVER);
  wire wr_vin_uv = wr_en & (paddr == pwm_pkg::OFF_VIN_UNDER);
  wire wr_aux_ov = wr_en & (paddr == pwm_pkg::OFF_AUX_OVER);
  wire wr_aux_uv = wr_en & (paddr == pwm_pkg::OFF_AUX_UNDER);
  wire wr_cur_oc = wr_en & (paddr == pwm_pkg::OFF_CUR_OVER);
  wire wr_pwr_op = wr_en & (paddr == pwm_pkg::OFF_PWR_OVER);

  // ****************************************************************
  // Limits
  // ****************************************************************
  logic [15:0] vin_ov_r, vin_uv_r, aux_ov_r, aux_uv_r, cur_oc_r, pwr_op_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_ov_r <= pwm_pkg::LIM_VOLT_OVER_RST;
      vin_uv_r <= pwm_pkg::LIM_UNDER_RST;
      aux_ov_r <= pwm_pkg::LIM_VOLT_OVER_RST;
      aux_uv_r <= pwm_pkg::LIM_UNDER_RST;
      cur_oc_r <= pwm_pkg::LIM_SIGNED_OVER_RST;
      pwr_op_r <= pwm_pkg::LIM_SIGNED_OVER_RST;
    end else begin
      if (wr_vin_ov) vin_ov_r <= pwdata[15:0];
      if (wr_vin_uv) vin_uv_r <= pwdata[15:0];
      if (wr_aux_ov) aux_ov_r <= pwdata[15:0];
      if (wr_aux_uv) aux_uv_r <= pwdata[15:0];
      if (wr_cur_oc) cur_oc_r <= pwdata[15:0];
      if (wr_pwr_op) pwr_op_r <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // Warning checks
  // ****************************************************************
  // Strict compares: a limit left at full scale can never be exceeded.
  wire w_vin_ov = vin_w > vin_ov_r;
  wire w_vin_uv = vin_w < vin_uv_r;
  wire w_aux_ov = aux_w > aux_ov_r;
  wire w_aux_uv = aux_w < aux_uv_r;
  wire w_cur_oc = cur_oc_r[15] ? ($signed(cur_w) < $signed(cur_oc_r))
                               : ($signed(cur_w) > $signed(cur_oc_r));
  wire w_pwr_op = pwr_op_r[15] ? ($signed(pwr_w) < $signed(pwr_op_r))
                               : ($signed(pwr_w) > $signed(pwr_op_r));
  wire [5:0] warn_w = {w_pwr_op, w_cur_oc, w_aux_uv, w_aux_ov,
                       w_vin_uv, w_vin_ov};

  logic [5:0] status_r;
  // Set wins over a clear in the same cycle so no event is lost
  wire [5:0] status_nxt = (sts_clr ? 6'h00 : status_r)
                        | (new_res ? warn_w : 6'h00);

  // ****************************************************************
  // Records and latest results
  // ****************************************************************
  logic [15:0] vin_r, aux_r, cur_r, pwr_r;
  logic [23:0] pwr_wide_r;
  logic [15:0] vin_h_r, aux_h_r, cur_h_r, cur_l_r, pwr_h_r, pwr_l_r;
  // A clear in the result cycle makes zero the base of the compare
  wire [15:0] vin_h_b = clr_vin_h ? pwm_pkg::RECORD_CLEAR : vin_h_r;
  wire [15:0] aux_h_b = clr_aux_h ? pwm_pkg::RECORD_CLEAR : aux_h_r;
  wire [15:0] cur_h_b = clr_cur_h ? pwm_pkg::RECORD_CLEAR : cur_h_r;
  wire [15:0] cur_l_b = clr_cur_l ? pwm_pkg::RECORD_CLEAR : cur_l_r;
  wire [15:0] pwr_h_b = clr_pwr_h ? pwm_pkg::RECORD_CLEAR : pwr_h_r;
  wire [15:0] pwr_l_b = clr_pwr_l ? pwm_pkg::RECORD_CLEAR : pwr_l_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {vin_r, aux_r, cur_r, pwr_r} <= '0;
      pwr_wide_r <= '0;
      {vin_h_r, aux_h_r, cur_h_r, cur_l_r, pwr_h_r, pwr_l_r} <= '0;
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
      if (new_res) begin
        vin_r <= vin_w;
        aux_r <= aux_w;
        cur_r <= cur_w;
        pwr_r <= pwr_w;
        pwr_wide_r <= pwr_wide_w;
        vin_h_r <= (vin_w > vin_h_b) ? vin_w : vin_h_b;
        aux_h_r <= (aux_w > aux_h_b) ? aux_w : aux_h_b;
        cur_h_r <= smax(cur_h_b, cur_w);
        cur_l_r <= smin(cur_l_b, cur_w);
        pwr_h_r <= smax(pwr_h_b, pwr_w);
        pwr_l_r <= smin(pwr_l_b, pwr_w);
      end else begin
        vin_h_r <= vin_h_b;
        aux_h_r <= aux_h_b;
        cur_h_r <= cur_h_b;
        cur_l_r <= cur_l_b;
        pwr_h_r <= pwr_h_b;
        pwr_l_r <= pwr_l_b;
      end
    end
  end

  // ****************************************************************
  // Energy metering
  // ****************************************************************
  // Each direction keeps {rollover, accumulator} as one unsigned word.
  logic [39:0] efwd_r, erev_r;
  logic [23:0] samples_r;
  wire [23:0] pwr_mag = pwr_wide_w[23] ? (~pwr_wide_w + 24'h000001)
                                       : pwr_wide_w;
  wire [39:0] efwd_nxt = efwd_r + {16'h0000, pwr_mag};
  wire [39:0] erev_nxt = erev_r + {16'h0000, pwr_mag};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      efwd_r <= '0;
      erev_r <= '0;
      samples_r <= '0;
    end else if (new_res) begin
      samples_r <= samples_r + 24'h000001;
      if (pwr_wide_w[23]) erev_r <= erev_nxt;
      else efwd_r <= efwd_nxt;
    end
  end

  // ****************************************************************
  // APB read and answer
  // ****************************************************************
  logic [31:0] rd_mux;
  logic rd_err;

  always_comb begin
    rd_err = 1'b0;
    unique case (paddr)
      pwm_pkg::OFF_VIN: rd_mux = {16'h0000, vin_r};
      pwm_pkg::OFF_AUX: rd_mux = {16'h0000, aux_r};
      pwm_pkg::OFF_CUR: rd_mux = {16'h0000, cur_r};
      pwm_pkg::OFF_PWR: rd_mux = {16'h0000, pwr_r};
      pwm_pkg::OFF_PWR_WIDE: rd_mux = {8'h00, pwr_wide_r};
      pwm_pkg::OFF_VIN_HIGH: rd_mux = {16'h0000, vin_h_r};
      pwm_pkg::OFF_AUX_HIGH: rd_mux = {16'h0000, aux_h_r};
      pwm_pkg::OFF_CUR_HIGH: rd_mux = {16'h0000, cur_h_r};
      pwm_pkg::OFF_CUR_LOW: rd_mux = {16'h0000, cur_l_r};
      pwm_pkg::OFF_PWR_HIGH: rd_mux = {16'h0000, pwr_h_r};
      pwm_pkg::OFF_PWR_LOW: rd_mux = {16'h0000, pwr_l_r};
      pwm_pkg::OFF_VIN_OVER: rd_mux = {16'h0000, vin_ov_r};
      pwm_pkg::OFF_VIN_UNDER: rd_mux = {16'h0000, vin_uv_r};
      pwm_pkg::OFF_AUX_OVER: rd_mux = {16'h0000, aux_ov_r};
      pwm_pkg::OFF_AUX_UNDER: rd_mux = {16'h0000, aux_uv_r};
      pwm_pkg::OFF_CUR_OVER: rd_mux = {16'h0000, cur_oc_r};
      pwm_pkg::OFF_PWR_OVER: rd_mux = {16'h0000, pwr_op_r};
      pwm_pkg::OFF_STATUS: rd_mux = {26'h0000000, status_r};
      pwm_pkg::OFF_EFWD_ACC: rd_mux = {8'h00, efwd_r[23:0]};
      pwm_pkg::OFF_EFWD_ROLL: rd_mux = {16'h0000, efwd_r[39:24]};
      pwm_pkg::OFF_EREV_ACC: rd_mux = {8'h00, erev_r[23:0]};
      pwm_pkg::OFF_EREV_ROLL: rd_mux = {16'h0000, erev_r[39:24]};
      pwm_pkg::OFF_SAMPLES: rd_mux = {8'h00, samples_r};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // Answer is registered in the setup cycle: every access phase is one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready_r <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel & ~penable & rd_err;
    end
  end

  assign pready = pready_r;
  assign warn_flags = status_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_CUR_HIGH: assert property (new_res |=>
    $signed(cur_h_r) >= $signed($past(cur_w)))
    else $error("current high record below latest result");
  AST_CUR_LOW: assert property (new_res |=>
    $signed(cur_l_r) <= $signed($past(cur_w)))
    else $error("current low record above latest result");
  AST_VIN_HIGH: assert property (new_res |=> vin_h_r >= $past(vin_w))
    else $error("input voltage record below latest result");
  AST_REC_HOLD: assert property (!new_res && !wr_en |=>
    $stable(cur_h_r) && $stable(pwr_l_r) && $stable(vin_h_r))
    else $error("record changed without a result");
  AST_CLEAR_ONE: assert property (clr_cur_h && !new_res |=>
    cur_h_r == 16'h0000 && $stable(cur_l_r) && $stable(pwr_h_r))
    else $error("record clear wrong or touched another record");
  AST_STRICT_EQ: assert property (new_res && vin_w == vin_ov_r &&
    !status_r[pwm_pkg::ST_VIN_OV] |=> !status_r[pwm_pkg::ST_VIN_OV])
    else $error("equality raised a warning");
  AST_OC_SET: assert property (new_res && !cur_oc_r[15] &&
    $signed(cur_w) > $signed(cur_oc_r) |=> status_r[pwm_pkg::ST_CUR_OC])
    else $error("overcurrent not flagged");
  AST_STICKY: assert property (!sts_clr |=>
    (status_r & $past(status_r)) == $past(status_r))
    else $error("warning bit dropped without clear");
  AST_PWR_STD: assert property (new_res |=>
    pwr_r == pwr_wide_r[23:8] ##1 pwr_r == pwr_wide_r[23:8])
    else $error("standard power not upper bits of wide power");
  AST_APB_ANS: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("slave answer not one cycle");
endmodule

`default_nettype wire

// [pwm_front_model.sv]
// Behavioural model of the averaging front end that feeds the monitor
`timescale 1ns/1ps
`default_nettype none

module pwm_front_model (
  input wire logic link_clk,
  output logic fe_done_toggle,
  output logic [pwm_pkg::CODE_W-1:0] fe_vin_code,
  output logic [pwm_pkg::CODE_W-1:0] fe_aux_code,
  output logic [pwm_pkg::CODE_W-1:0] fe_cur_code
);
  initial begin
    fe_done_toggle = 1'b0;
    fe_vin_code = 12'h000;
    fe_aux_code = 12'h000;
    fe_cur_code = 12'h000;
  end

  // ****************************************************************
  // One averaged result per call
  // ****************************************************************
  // Codes settle a full link period before the flip and are held until
  // the next call sets new ones, so the monitor never sees a half-updated set.
  task automatic send(input logic [11:0] v, input logic [11:0] a,
                      input logic [11:0] c);
    @(posedge link_clk);
    fe_vin_code <= v;
    fe_aux_code <= a;
    fe_cur_code <= c;
    @(posedge link_clk);
    fe_done_toggle <= ~fe_done_toggle;
    // Spacing far above the minimum lets the result land before reads
    repeat (2) @(posedge link_clk);
  endtask
endmodule

`default_nettype wire

// [pwm_monitor_test.sv]
// Self-checking testbench of the peak and warning monitor
`timescale 1ns/1ps
`default_nettype none

module pwm_monitor_test;
  logic ref_clk, rst_n, psel, penable, pwrite, link_clk;
  logic [pwm_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, rerr, fe_done_toggle;
  logic [pwm_pkg::CODE_W-1:0] fe_vin_code, fe_aux_code, fe_cur_code;
  logic [pwm_pkg::ST_W-1:0] warn_flags;
  int failures, compares;

  pwm_monitor i_pwm_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fe_done_toggle(fe_done_toggle),
    .fe_vin_code(fe_vin_code), .fe_aux_code(fe_aux_code),
    .fe_cur_code(fe_cur_code), .warn_flags(warn_flags));

  pwm_front_model i_pwm_front_model (
    .link_clk(link_clk), .fe_done_toggle(fe_done_toggle),
    .fe_vin_code(fe_vin_code), .fe_aux_code(fe_aux_code),
    .fe_cur_code(fe_cur_code));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  initial link_clk = 1'b0;
  always #80 link_clk = ~link_clk;

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic finish_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is seen high; the wait is bounded
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("BAD %0t no bus answer", $time);
      finish_test;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(pwm_pkg::OFF_VIN_OVER, 32'h0fff);
    rd(pwm_pkg::OFF_VIN_UNDER, 32'h0);
    rd(pwm_pkg::OFF_AUX_OVER, 32'h0fff);
    rd(pwm_pkg::OFF_AUX_UNDER, 32'h0);
    rd(pwm_pkg::OFF_CUR_OVER, 32'h7fff);
    rd(pwm_pkg::OFF_PWR_OVER, 32'h7fff);
    // Forward result, then a reverse one
    i_pwm_front_model.send(12'h064, 12'h032, 12'h00a);
    rd(pwm_pkg::OFF_VIN_HIGH, 32'h0064);
    rd(pwm_pkg::OFF_CUR_LOW, 32'h0);
    rd(pwm_pkg::OFF_PWR_WIDE, 32'h0003e8);
    rd(pwm_pkg::OFF_PWR, 32'h0003);
    rd(pwm_pkg::OFF_STATUS, 32'h0);
    i_pwm_front_model.send(12'h0c8, 12'h028, 12'hffb);
    rd(pwm_pkg::OFF_CUR, 32'hfffb);
    chk({31'h0, rerr}, 32'h0);
    rd(pwm_pkg::OFF_VIN, 32'h00c8);
    rd(pwm_pkg::OFF_AUX, 32'h0028);
    rd(pwm_pkg::OFF_CUR_HIGH, 32'h000a);
    rd(pwm_pkg::OFF_CUR_LOW, 32'hfffb);
    rd(pwm_pkg::OFF_PWR_WIDE, 32'hfffc18);
    rd(pwm_pkg::OFF_PWR, 32'hfffc);
    rd(pwm_pkg::OFF_PWR_HIGH, 32'h0003);
    rd(pwm_pkg::OFF_PWR_LOW, 32'hfffc);
    rd(pwm_pkg::OFF_VIN_HIGH, 32'h00c8);
    rd(pwm_pkg::OFF_AUX_HIGH, 32'h0032);
    rd(pwm_pkg::OFF_EFWD_ACC, 32'h0003e8);
    rd(pwm_pkg::OFF_EREV_ACC, 32'h0003e8);
    rd(pwm_pkg::OFF_EFWD_ROLL, 32'h0);
    rd(pwm_pkg::OFF_EREV_ROLL, 32'h0);
    rd(pwm_pkg::OFF_SAMPLES, 32'h000002);
    // Single-record clear; a nonzero write must not clear
    wr(pwm_pkg::OFF_CUR_LOW, 32'h0);
    rd(pwm_pkg::OFF_CUR_LOW, 32'h0);
    rd(pwm_pkg::OFF_CUR_HIGH, 32'h000a);
    wr(pwm_pkg::OFF_VIN_HIGH, 32'h0005);
    rd(pwm_pkg::OFF_VIN_HIGH, 32'h00c8);
    wr(pwm_pkg::OFF_VIN_OVER, 32'h012c);
    wr(pwm_pkg::OFF_VIN_UNDER, 32'h0064);
    wr(pwm_pkg::OFF_AUX_OVER, 32'h003c);
    wr(pwm_pkg::OFF_AUX_UNDER, 32'h001e);
    wr(pwm_pkg::OFF_CUR_OVER, 32'hfffb);
    wr(pwm_pkg::OFF_PWR_OVER, 32'h0003);
    // Voltages and current exactly at their limits; power below its limit
    i_pwm_front_model.send(12'h12c, 12'h03c, 12'hffb);
    rd(pwm_pkg::OFF_STATUS, 32'h0);
    rd(pwm_pkg::OFF_CUR_LOW, 32'hfffb);
    i_pwm_front_model.send(12'h12d, 12'h01d, 12'hffa);
    rd(pwm_pkg::OFF_STATUS, 32'h0019);
    chk({26'h0, warn_flags}, 32'h0019);
    i_pwm_front_model.send(12'h063, 12'h03d, 12'h014);
    rd(pwm_pkg::OFF_STATUS, 32'h003f);
    wr(pwm_pkg::OFF_STATUS, 32'h0);
    rd(pwm_pkg::OFF_STATUS, 32'h0);
    chk({26'h0, warn_flags}, 32'h0);
    // Clear the other current record; positive current and negative power
    wr(pwm_pkg::OFF_CUR_HIGH, 32'h0);
    rd(pwm_pkg::OFF_CUR_HIGH, 32'h0);
    rd(pwm_pkg::OFF_CUR_LOW, 32'hfffa);
    wr(pwm_pkg::OFF_CUR_OVER, 32'h0010);
    wr(pwm_pkg::OFF_PWR_OVER, 32'hfff0);
    i_pwm_front_model.send(12'h064, 12'h02a, 12'h011);
    rd(pwm_pkg::OFF_STATUS, 32'h0010);
    rd(pwm_pkg::OFF_CUR_HIGH, 32'h0011);
    i_pwm_front_model.send(12'h0c8, 12'h02a, 12'hec0);
    rd(pwm_pkg::OFF_STATUS, 32'h0030);
    chk({26'h0, warn_flags}, 32'h0030);
    rd(pwm_pkg::OFF_CUR_HIGH, 32'h0011);
    rd(pwm_pkg::OFF_CUR_LOW, 32'hfec0);
    rd(8'h5c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    finish_test;
  end
endmodule

`default_nettype wire
